// ===== src/uobpd_pkg.sv
// Purpose: Shared constants and types of the OTG buffer, pad and detect block
// Assumes: 32-bit APB register access, one word per register
// Notes:   Timeouts are kept in microseconds and turned into cycles in the core

package uobpd_pkg;

	// ==========================================================
	// Clock and sizes
	localparam int unsigned CLK_MHZ     = 100;
	localparam int unsigned PTR_W       = 16;
	localparam int unsigned RAM_BYTES   = 4096;
	localparam int unsigned NUM_REGIONS = 10;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_RSEL = 8'h08;
	localparam logic [7:0] OFS_RCFG = 8'h0C;
	localparam logic [7:0] OFS_RPTR = 8'h10;

	// Control register fields
	localparam int unsigned CTRL_ENABLE    = 0;
	localparam int unsigned CTRL_DETACH    = 1;
	localparam int unsigned CTRL_PINSEL    = 2;
	localparam int unsigned CTRL_SOFTROLE  = 3;
	localparam int unsigned CTRL_UNLOCK    = 4;
	localparam int unsigned CTRL_FREEZE    = 5;
	localparam int unsigned CTRL_PAGE_LSB  = 8;
	localparam int unsigned CTRL_VALUE_LSB = 12;

	localparam logic       RST_ENABLE   = 1'b0;
	localparam logic       RST_DETACH   = 1'b1;
	localparam logic       RST_PINSEL   = 1'b1;
	localparam logic       RST_SOFTROLE = 1'b1;
	localparam logic       RST_FREEZE   = 1'b1;
	localparam logic [1:0] RST_TVALUE   = 2'h0;

	// Status register fields
	localparam int unsigned STAT_ID     = 0;
	localparam int unsigned STAT_VBUS   = 1;
	localparam int unsigned STAT_IDEV   = 2;
	localparam int unsigned STAT_VBEV   = 3;
	localparam int unsigned STAT_SUSPEND_FLAG   = 4;
	localparam int unsigned STAT_WAKE   = 5;
	localparam int unsigned STAT_PADACT = 6;

	// Region configuration fields
	localparam int unsigned RCFG_REGION_ALLOCATE    = 0;
	localparam int unsigned RCFG_ENABLE   = 1;
	localparam int unsigned RCFG_BANK_LSB = 2;
	localparam int unsigned RCFG_SIZE_LSB = 4;
	localparam int unsigned RCFG_DIR      = 7;
	localparam int unsigned RCFG_TYPE_LSB = 8;
	localparam int unsigned RCFG_EP_LSB   = 10;
	localparam int unsigned RCFG_POLL_LSB = 16;
	localparam int unsigned RCFG_CONFIG_VALID    = 31;

	// Per-index limits: bank code 0..2 means 1..3 banks, size code n means 8<<n bytes
	localparam logic [1:0] EP0_MAX_BANK = 2'h0;
	localparam logic [1:0] EPN_MAX_BANK = 2'h2;
	localparam logic [2:0] EP0_MAX_SIZE = 3'h3;
	localparam logic [2:0] EPN_MAX_SIZE = 3'h7;

	// ==========================================================
	// OTG timer table, microseconds, [page][value]
	localparam int unsigned TIMEOUT_US [4][4] = '{
		'{20000, 50000, 70000, 100000},
		'{15000, 23000, 31000, 40000},
		'{93000, 105000, 118000, 131000},
		'{10, 100, 1000, 11000}
	};

	typedef enum logic [1:0] {
		PAGE_AWAIT_VRISE = 2'h0,
		PAGE_VBUS_PULSE  = 2'h1,
		PAGE_PULLDOWN    = 2'h2,
		PAGE_SRP_DETECT  = 2'h3
	} uobpd_timer_page_e;

	typedef enum logic {
		PAD_IDLE   = 1'b0,
		PAD_ACTIVE = 1'b1
	} uobpd_pad_state_e;

	// Low bits line up with the configuration register
	typedef struct packed {
		logic [7:0] pollInterval;
		logic [3:0] targetEp;
		logic [1:0] transferType;
		logic       direction;
		logic [2:0] bufferSize;
		logic [1:0] bankCount;
		logic       enable;
		logic       regionAllocate;
	} uobpd_region_cfg_s;

	typedef struct packed {
		logic diffRxEnable;
		logic pullDownDp;
		logic pullDownDm;
	} uobpd_pad_ctl_s;

endpackage

// ===== src/uobpd_core.sv
// Purpose: Packet RAM window allocation, pad idle control, OTG timer selection
//          and supply / role plug detection, behind an APB register file
// Assumes: suspendDetect and nonIdleDetect are single-cycle pulses on core_clk;
//          comparator and role pin inputs are asynchronous
// Notes:   Region contents are not held here; a slid window is reported by pulse
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.

`timescale 1ns/1ps

// Summary of operation
// - Regions allocate ascending from index zero
// - Allocate inserts region, next slides up, lost
// - Disabling keeps allocate bit and configuration
// - Freeing region slides next one down, lost
// - Same reallocation restores identical pointer and size
// - Config valid only if size, banks fit
// - Idle pad: receiver off, pull-downs on
// - Suspend sets suspend, clears wake, idles pad
// - Non-idle event sets wake, activates pad
// - Disabled or detached forces pad idle
// - Page field selects one of four timers
// - Pages zero and one timeout values
// - Pages two and three timeout values
// - Page and value writes need unlock
// - Device role: supply bit follows session valid
// - Host role: supply bit uses hysteresis
// - Supply change event; works while disabled
// - Role from pin or software select
// - Default pin select and device role
// - Role change event; works while disabled
// - Low role pin means host role
module uobpd_core #(
	parameter int unsigned NUM_REGIONS = uobpd_pkg::NUM_REGIONS,
	parameter int unsigned RAM_BYTES   = uobpd_pkg::RAM_BYTES,
	parameter int unsigned CLK_MHZ     = uobpd_pkg::CLK_MHZ,
	parameter int unsigned TIMEOUT_US [4][4] = uobpd_pkg::TIMEOUT_US
) (
	// Clock, reset, enable
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire logic                 clkEn,
	// APB slave
	input  wire logic [7:0]           paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Bus events from the link logic
	input  wire logic                 suspendDetect,
	input  wire logic                 nonIdleDetect,
	// Asynchronous pad inputs
	input  wire logic                 rolePinIn,
	input  wire logic                 sessionValidCmp,
	input  wire logic                 aSupplyOkCmp,
	// Pad and controller outputs
	output uobpd_pkg::uobpd_pad_ctl_s padCtl,
	output logic                      padActive,
	output logic                      controllerEnable,
	output logic                      clockFreeze,
	output logic                      hostRole,
	output logic                      vbusPresent,
	output logic                      roleChangePulse,
	output logic                      vbusChangePulse,
	// Region slide report
	output logic                      regionLostPulse,
	output logic      [3:0]           regionLostIndex,
	// Selected timeout per page, in core_clk cycles
	output logic      [3:0][31:0]     timeoutCycles
);

	localparam int unsigned PW = uobpd_pkg::PTR_W;

	// ==========================================================
	// Helpers
	function automatic logic [PW-1:0] regionBytes(input logic [1:0] bank,
		input logic [2:0] size);
		logic [PW-1:0] one;
		one = {{(PW-2){1'b0}}, bank} + {{(PW-1){1'b0}}, 1'b1};
		return one << ({1'b0, size} + 4'h3);
	endfunction

	function automatic logic configFits(input logic [3:0] idx, input logic [1:0] bank,
		input logic [2:0] size);
		logic [1:0] maxBank;
		logic [2:0] maxSize;
		maxBank = (idx == 4'h0) ? uobpd_pkg::EP0_MAX_BANK : uobpd_pkg::EPN_MAX_BANK;
		maxSize = (idx == 4'h0) ? uobpd_pkg::EP0_MAX_SIZE : uobpd_pkg::EPN_MAX_SIZE;
		return (bank <= maxBank) && (size <= maxSize)
			&& (32'(regionBytes(bank, size)) <= RAM_BYTES);
	endfunction

	// ==========================================================
	// State
	logic                          dataReady_q;
	logic [31:0]                   rdData_q;
	logic                          slvErr_q;
	logic [31:0]                   rdMux;
	logic                          rdMapped;
	logic                          wrEn;

	logic                          enable_q;
	logic                          detach_q;
	logic                          pinSel_q;
	logic                          softRole_q;
	logic                          freeze_q;
	logic                          unlock_q;
	logic [1:0]                    page_q;
	logic [1:0]                    tValue_q [4];
	logic [1:0]                    pageNext;

	logic [2:0]                    pinMeta_q;
	logic [2:0]                    pinSync_q;
	logic                          idStatus_q;
	logic                          vbus_q;
	logic                          idEvent_q;
	logic                          vbEvent_q;
	logic                          idPulse_q;
	logic                          vbPulse_q;
	logic                          idNext;
	logic                          vbusNext;

	logic                          suspend_flag_q;
	logic                          wake_q;
	uobpd_pkg::uobpd_pad_state_e   padState_q;
	logic                          forcedPrev_q;
	logic                          padForced;

	logic [3:0]                    sel_q;
	uobpd_pkg::uobpd_region_cfg_s  cfg_q [NUM_REGIONS];
	logic                          config_valid_q [NUM_REGIONS];
	logic [PW-1:0]                 base_q [NUM_REGIONS];
	logic [PW-1:0]                 size_q [NUM_REGIONS];
	logic                          lostPulse_q;
	logic [3:0]                    lostIdx_q;
	logic                          selValid;

	// ==========================================================
	// APB slave: no wait states, read data captured in setup
	assign pready  = clkEn & dataReady_q;
	assign prdata  = rdData_q;
	assign pslverr = slvErr_q;
	assign wrEn    = psel & penable & pready & pwrite;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dataReady_q <= 1'b0;
			rdData_q    <= 32'h00000000;
			slvErr_q    <= 1'b0;
		end else if (clkEn) begin
			dataReady_q <= psel & ~(penable & dataReady_q);
			if (psel & ~penable) begin
				rdData_q <= pwrite ? 32'h00000000 : rdMux;
				slvErr_q <= ~rdMapped;
			end
		end
	end

	assign selValid = (32'(sel_q) < NUM_REGIONS);

	always_comb begin
		rdMux    = 32'h00000000;
		rdMapped = 1'b1;
		case (paddr)
			uobpd_pkg::OFS_CTRL: begin
				rdMux[uobpd_pkg::CTRL_ENABLE]   = enable_q;
				rdMux[uobpd_pkg::CTRL_DETACH]   = detach_q;
				rdMux[uobpd_pkg::CTRL_PINSEL]   = pinSel_q;
				rdMux[uobpd_pkg::CTRL_SOFTROLE] = softRole_q;
				rdMux[uobpd_pkg::CTRL_FREEZE]   = freeze_q;
				rdMux[uobpd_pkg::CTRL_PAGE_LSB +: 2]  = page_q;
				rdMux[uobpd_pkg::CTRL_VALUE_LSB +: 2] = tValue_q[page_q];
			end
			uobpd_pkg::OFS_STAT: begin
				rdMux[uobpd_pkg::STAT_ID]     = idStatus_q;
				rdMux[uobpd_pkg::STAT_VBUS]   = vbus_q;
				rdMux[uobpd_pkg::STAT_IDEV]   = idEvent_q;
				rdMux[uobpd_pkg::STAT_VBEV]   = vbEvent_q;
				rdMux[uobpd_pkg::STAT_SUSPEND_FLAG]   = suspend_flag_q;
				rdMux[uobpd_pkg::STAT_WAKE]   = wake_q;
				rdMux[uobpd_pkg::STAT_PADACT] = padActive;
			end
			uobpd_pkg::OFS_RSEL: rdMux[3:0] = sel_q;
			uobpd_pkg::OFS_RCFG: begin
				if (selValid) begin
					rdMux[uobpd_pkg::RCFG_EP_LSB+3:0] = cfg_q[sel_q][uobpd_pkg::RCFG_EP_LSB+3:0];
					rdMux[uobpd_pkg::RCFG_POLL_LSB +: 8] = cfg_q[sel_q].pollInterval;
					rdMux[uobpd_pkg::RCFG_CONFIG_VALID] = config_valid_q[sel_q];
				end
			end
			uobpd_pkg::OFS_RPTR: begin
				if (selValid) begin
					rdMux = {size_q[sel_q], base_q[sel_q]};
				end
			end
			default: rdMapped = 1'b0;
		endcase
	end

	// ==========================================================
	// Control register and OTG timer pages
	// Unlock arms for the next control write; the same write may also carry it
	always_comb begin
		pageNext = page_q;
		if (pwdata[uobpd_pkg::CTRL_UNLOCK] | unlock_q) begin
			pageNext = pwdata[uobpd_pkg::CTRL_PAGE_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			enable_q   <= uobpd_pkg::RST_ENABLE;
			detach_q   <= uobpd_pkg::RST_DETACH;
			pinSel_q   <= uobpd_pkg::RST_PINSEL;
			softRole_q <= uobpd_pkg::RST_SOFTROLE;
			freeze_q   <= uobpd_pkg::RST_FREEZE;
			unlock_q   <= 1'b0;
			page_q     <= uobpd_pkg::PAGE_AWAIT_VRISE;
			for (int p = 0; p < 4; p++) begin
				tValue_q[p] <= uobpd_pkg::RST_TVALUE;
			end
		end else if (clkEn && wrEn && paddr == uobpd_pkg::OFS_CTRL) begin
			enable_q   <= pwdata[uobpd_pkg::CTRL_ENABLE];
			detach_q   <= pwdata[uobpd_pkg::CTRL_DETACH];
			pinSel_q   <= pwdata[uobpd_pkg::CTRL_PINSEL];
			softRole_q <= pwdata[uobpd_pkg::CTRL_SOFTROLE];
			freeze_q   <= pwdata[uobpd_pkg::CTRL_FREEZE];
			unlock_q   <= pwdata[uobpd_pkg::CTRL_UNLOCK];
			page_q     <= pageNext;
			if (pwdata[uobpd_pkg::CTRL_UNLOCK] | unlock_q) begin
				tValue_q[pageNext] <= pwdata[uobpd_pkg::CTRL_VALUE_LSB +: 2];
			end
		end
	end

	// Table entries are microseconds; cycles follow the clock rate
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			timeoutCycles[p] = 32'(TIMEOUT_US[p][tValue_q[p]] * CLK_MHZ);
		end
	end

	assign controllerEnable = enable_q;
	assign clockFreeze      = freeze_q;

	// ==========================================================
	// Pin synchronisers and plug detection
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pinMeta_q <= 3'h1;
			pinSync_q <= 3'h1;
		end else if (clkEn) begin
			pinMeta_q <= {aSupplyOkCmp, sessionValidCmp, rolePinIn};
			pinSync_q <= pinMeta_q;
		end
	end

	// Low pin grounds the role: host
	assign idNext = pinSel_q ? pinSync_q[0] : softRole_q;

	always_comb begin
		vbusNext = vbus_q;
		if (idStatus_q) begin
			vbusNext = pinSync_q[1];
		end else if (pinSync_q[2]) begin
			vbusNext = 1'b1;
		end else if (!pinSync_q[1]) begin
			vbusNext = 1'b0;
		end
	end

	// Not gated by the controller enable: detection runs while disabled
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			idStatus_q <= 1'b1;
			vbus_q     <= 1'b0;
			idPulse_q  <= 1'b0;
			vbPulse_q  <= 1'b0;
		end else if (clkEn) begin
			idStatus_q <= idNext;
			vbus_q     <= vbusNext;
			idPulse_q  <= idNext ^ idStatus_q;
			vbPulse_q  <= vbusNext ^ vbus_q;
		end
	end

	// Sticky events, write one to clear; a new edge beats the clear
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			idEvent_q <= 1'b0;
			vbEvent_q <= 1'b0;
		end else if (clkEn) begin
			if (idPulse_q) begin
				idEvent_q <= 1'b1;
			end else if (wrEn && paddr == uobpd_pkg::OFS_STAT && pwdata[uobpd_pkg::STAT_IDEV]) begin
				idEvent_q <= 1'b0;
			end
			if (vbPulse_q) begin
				vbEvent_q <= 1'b1;
			end else if (wrEn && paddr == uobpd_pkg::OFS_STAT && pwdata[uobpd_pkg::STAT_VBEV]) begin
				vbEvent_q <= 1'b0;
			end
		end
	end

	assign hostRole        = ~idStatus_q;
	assign vbusPresent     = vbus_q;
	assign roleChangePulse = idPulse_q;
	assign vbusChangePulse = vbPulse_q;

	// ==========================================================
	// Suspend / wake flags and pad state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			suspend_flag_q <= 1'b0;
			wake_q <= 1'b0;
		end else if (clkEn) begin
			if (suspendDetect) begin
				suspend_flag_q <= 1'b1;
				wake_q <= 1'b0;
			end else if (nonIdleDetect) begin
				wake_q <= 1'b1;
				suspend_flag_q <= 1'b0;
			end else if (wrEn && paddr == uobpd_pkg::OFS_STAT) begin
				if (pwdata[uobpd_pkg::STAT_SUSPEND_FLAG]) begin
					suspend_flag_q <= 1'b0;
				end
				if (pwdata[uobpd_pkg::STAT_WAKE]) begin
					wake_q <= 1'b0;
				end
			end
		end
	end

	assign padForced = ~enable_q | detach_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			padState_q   <= uobpd_pkg::PAD_IDLE;
			forcedPrev_q <= 1'b1;
		end else if (clkEn) begin
			forcedPrev_q <= padForced;
			case (padState_q)
				uobpd_pkg::PAD_IDLE: begin
					if (!padForced && (forcedPrev_q || nonIdleDetect)) begin
						padState_q <= uobpd_pkg::PAD_ACTIVE;
					end
				end
				uobpd_pkg::PAD_ACTIVE: begin
					if (padForced || suspendDetect) begin
						padState_q <= uobpd_pkg::PAD_IDLE;
					end
				end
				default: padState_q <= uobpd_pkg::PAD_IDLE;
			endcase
		end
	end

	assign padActive           = (padState_q == uobpd_pkg::PAD_ACTIVE);
	assign padCtl.diffRxEnable = padActive;
	assign padCtl.pullDownDp   = ~padActive;
	assign padCtl.pullDownDm   = ~padActive;

	// ==========================================================
	// Packet RAM windows
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sel_q <= 4'h0;
		end else if (clkEn && wrEn && paddr == uobpd_pkg::OFS_RSEL) begin
			sel_q <= pwdata[3:0];
		end
	end

	// Pointers only; overlap is not checked
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				cfg_q[i]   <= '0;
				config_valid_q[i] <= 1'b0;
				base_q[i]  <= '0;
				size_q[i]  <= '0;
			end
			lostPulse_q <= 1'b0;
			lostIdx_q   <= 4'h0;
		end else if (clkEn) begin
			lostPulse_q <= 1'b0;
			if (wrEn && paddr == uobpd_pkg::OFS_RCFG && selValid) begin
				// Enable bit is independent of the rest of the configuration
				cfg_q[sel_q] <= {pwdata[uobpd_pkg::RCFG_POLL_LSB +: 8],
					pwdata[uobpd_pkg::RCFG_EP_LSB+3:0]};
				if (pwdata[uobpd_pkg::RCFG_REGION_ALLOCATE] && !cfg_q[sel_q].regionAllocate) begin
					logic [PW-1:0] lowerEnd;
					logic [PW-1:0] newSize;
					lowerEnd = (sel_q == 4'h0) ? '0
						: base_q[sel_q - 4'h1] + size_q[sel_q - 4'h1];
					newSize = regionBytes(pwdata[uobpd_pkg::RCFG_BANK_LSB +: 2],
						pwdata[uobpd_pkg::RCFG_SIZE_LSB +: 3]);
					base_q[sel_q]  <= lowerEnd;
					size_q[sel_q]  <= newSize;
					config_valid_q[sel_q] <= configFits(sel_q,
						pwdata[uobpd_pkg::RCFG_BANK_LSB +: 2],
						pwdata[uobpd_pkg::RCFG_SIZE_LSB +: 3]);
					if ((32'(sel_q) + 1 < NUM_REGIONS) && cfg_q[sel_q + 4'h1].regionAllocate) begin
						base_q[sel_q + 4'h1] <= lowerEnd + newSize;
						lostPulse_q <= 1'b1;
						lostIdx_q   <= sel_q + 4'h1;
					end
				end else if (!pwdata[uobpd_pkg::RCFG_REGION_ALLOCATE] && cfg_q[sel_q].regionAllocate) begin
					size_q[sel_q]  <= '0;
					config_valid_q[sel_q] <= 1'b0;
					if ((32'(sel_q) + 1 < NUM_REGIONS) && cfg_q[sel_q + 4'h1].regionAllocate) begin
						base_q[sel_q + 4'h1] <= base_q[sel_q];
						lostPulse_q <= 1'b1;
						lostIdx_q   <= sel_q + 4'h1;
					end
				end
			end
		end
	end

	assign regionLostPulse = lostPulse_q;
	assign regionLostIndex = lostIdx_q;

endmodule

// ===== verification/uobpd_core_chk_sva.sv
// Purpose: Port-level assertions for the buffer, pad and detect core
// Assumes: clkEn low freezes all state
// Notes:   Synced checks wait four running edges after reset
`timescale 1ns/1ps
module uobpd_core_chk (
	// Clock and reset
	input wire logic             core_clk,
	input wire logic             reset,
	input wire logic             clkEn,
	// Bus
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic             pready,
	input wire logic [7:0]       paddr,
	// Events and pad inputs
	input wire logic             suspendDetect,
	input wire logic             sessionValidCmp,
	input wire logic             aSupplyOkCmp,
	// Watched outputs
	input wire logic [2:0]       padCtl,
	input wire logic             padActive,
	input wire logic             controllerEnable,
	input wire logic             hostRole,
	input wire logic             vbusPresent,
	input wire logic             roleChangePulse,
	input wire logic             vbusChangePulse,
	input wire logic             regionLostPulse,
	input wire logic [3:0][31:0] timeoutCycles
);
	// ==========================================================
	logic [2:0] warm_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			warm_q <= 3'h0;
		else if (!clkEn)
			warm_q <= 3'h0;
		else if (warm_q != 3'h4)
			warm_q <= warm_q + 3'h1;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// ==========================================================
	// Properties
	property p_padCtl; padCtl == (padActive ? 3'h4 : 3'h3); endproperty
	a_padCtl: assert property (p_padCtl) else $error("pad controls wrong");
	property p_suspend_flag; clkEn && suspendDetect |=> !padActive; endproperty
	a_suspend_flag: assert property (p_suspend_flag) else $error("pad active after suspend");
	property p_off; (clkEn && !controllerEnable) [*2] |=> !padActive; endproperty
	a_off: assert property (p_off) else $error("pad active while disabled");
	property p_vbDev;
		warm_q == 3'h4 && !$past(hostRole) |-> vbusPresent == $past(sessionValidCmp, 3);
	endproperty
	a_vbDev: assert property (p_vbDev) else $error("supply bit not following");
	property p_vbSet; warm_q == 3'h4 && $past(hostRole) && $past(aSupplyOkCmp, 3) |-> vbusPresent;
	endproperty
	a_vbSet: assert property (p_vbSet) else $error("host supply not set");
	property p_vbClr;
		warm_q == 3'h4 && $past(hostRole) && !$past(sessionValidCmp, 3) |-> !vbusPresent;
	endproperty
	a_vbClr: assert property (p_vbClr) else $error("host supply not cleared");
	property p_vbEv;
		warm_q > 3'h1 |-> vbusChangePulse == (vbusPresent != $past(vbusPresent));
	endproperty
	a_vbEv: assert property (p_vbEv) else $error("supply event mismatch");
	property p_idEv;
		warm_q > 3'h1 |-> roleChangePulse == (hostRole != $past(hostRole));
	endproperty
	a_idEv: assert property (p_idEv) else $error("role event mismatch");
	property p_tmo; !(psel && penable && pready && pwrite) |=> $stable(timeoutCycles); endproperty
	a_tmo: assert property (p_tmo) else $error("timeout moved without write");
	property p_lost;
		regionLostPulse |-> $past(psel && penable && pready && pwrite &&
			paddr == uobpd_pkg::OFS_RCFG);
	endproperty
	a_lost: assert property (p_lost) else $error("slide without config write");
endmodule

bind uobpd_core uobpd_core_chk u_chk (.core_clk, .reset, .clkEn, .psel, .penable, .pwrite,
	.pready, .paddr, .suspendDetect, .sessionValidCmp, .aSupplyOkCmp, .padCtl, .padActive,
	.controllerEnable, .hostRole, .vbusPresent, .roleChangePulse, .vbusChangePulse,
	.regionLostPulse, .timeoutCycles);

// ===== verification/uobpd_pad_model.sv
// Purpose: Stand-in for the role pin and the supply comparators
// Assumes: role pin has a pull-up
// Notes:   A-valid never high without session valid, as on a real rail
`timescale 1ns/1ps
module uobpd_pad_model (
	// Clock
	input  wire logic core_clk,
	// Pin and comparators
	output logic      rolePinIn,
	output logic      sessionValidCmp,
	output logic      aSupplyOkCmp
);
	logic plugA = 1'b0;

	assign rolePinIn = ~plugA;

	initial begin
		sessionValidCmp = 1'b0;
		aSupplyOkCmp    = 1'b0;
	end

	task automatic drive(input logic a, input logic s, input logic v);
		@(posedge core_clk);
		plugA           <= a;
		sessionValidCmp <= s | v;
		aSupplyOkCmp    <= v;
	endtask
endmodule

// ===== verification/tb.sv
// Purpose: Self-checking bench for the buffer, pad and detect core
// Assumes: clkEn held high
// Notes:   Fixed waits follow the sync and event latencies
`timescale 1ns/1ps
module tb;
	logic             core_clk = 1'b0;
	logic             reset    = 1'b1;
	logic             clkEn    = 1'b1;
	logic             psel     = 1'b0;
	logic             penable  = 1'b0;
	logic             pwrite   = 1'b0;
	logic [7:0]       paddr    = 8'h00;
	logic [31:0]      pwdata   = 32'h0;
	logic             suspendDetect = 1'b0;
	logic             nonIdleDetect = 1'b0;
	logic [31:0]      prdata, rd;
	logic             pready, pslverr, err, padActive, controllerEnable, hostRole, clockFreeze;
	logic             vbusPresent, roleChangePulse, vbusChangePulse, regionLostPulse;
	logic             rolePinIn, sessionValidCmp, aSupplyOkCmp;
	logic [3:0]       regionLostIndex;
	logic [3:0][31:0] timeoutCycles;
	uobpd_pkg::uobpd_pad_ctl_s padCtl;
	int               n_fail = 0;
	int               comparisons = 0;

	uobpd_core dut (.core_clk, .reset, .clkEn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .suspendDetect, .nonIdleDetect, .rolePinIn,
		.sessionValidCmp, .aSupplyOkCmp, .padCtl, .padActive, .controllerEnable,
		.clockFreeze, .hostRole, .vbusPresent, .roleChangePulse, .vbusChangePulse,
		.regionLostPulse, .regionLostIndex, .timeoutCycles);
	uobpd_pad_model pad (.core_clk, .rolePinIn, .sessionValidCmp, .aSupplyOkCmp);

	initial forever #5 core_clk = ~core_clk;

	// ==========================================================
	// Shared tasks
	task automatic end_of_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] cy(input int p, input int v);
		return 32'(uobpd_pkg::TIMEOUT_US[p][v] * uobpd_pkg::CLK_MHZ);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Samples pready at rising edges only
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
			if (k > 50) begin
				n_fail++;
				end_of_test();
			end
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rg(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic cfg(input logic [31:0] i, input logic [31:0] d);
		wr(uobpd_pkg::OFS_RSEL, i);
		wr(uobpd_pkg::OFS_RCFG, d);
	endtask
	task automatic ptr(input logic [31:0] i, input logic [31:0] e);
		wr(uobpd_pkg::OFS_RSEL, i);
		rg(uobpd_pkg::OFS_RPTR);
		chk(rd, e);
	endtask
	task automatic pulse(input logic s);
		@(posedge core_clk);
		if (s)
			suspendDetect <= 1'b1;
		else
			nonIdleDetect <= 1'b1;
		@(posedge core_clk);
		suspendDetect <= 1'b0;
		nonIdleDetect <= 1'b0;
		cyc(2);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rg(uobpd_pkg::OFS_CTRL);
		chk(rd, 32'h0000_002E);
		chk(32'({clockFreeze, controllerEnable}), 32'h2);
		rg(uobpd_pkg::OFS_STAT);
		chk(rd & 32'h7F, 32'h01);
		chk(timeoutCycles[0], cy(0, 0));
		chk(timeoutCycles[3], cy(3, 0));
		rg(8'h40);
		chk({31'h0, err}, 32'h1);
	endtask
	task automatic t_plug;
		pad.drive(1'b0, 1'b1, 1'b0);
		cyc(6);
		rg(uobpd_pkg::OFS_STAT);
		chk(rd & 32'hF, 32'hB);
		pad.drive(1'b1, 1'b1, 1'b0);
		cyc(6);
		chk(32'({hostRole, vbusPresent}), 32'h3);
		rg(uobpd_pkg::OFS_STAT);
		chk(rd & 32'h5, 32'h4);
		pad.drive(1'b1, 1'b0, 1'b0);
		cyc(6);
		chk(32'(vbusPresent), 32'h0);
		pad.drive(1'b1, 1'b1, 1'b0);
		cyc(6);
		chk(32'(vbusPresent), 32'h0);
		pad.drive(1'b1, 1'b1, 1'b1);
		cyc(6);
		chk(32'(vbusPresent), 32'h1);
		pad.drive(1'b0, 1'b0, 1'b0);
		cyc(6);
		chk(32'({hostRole, vbusPresent}), 32'h0);
		wr(uobpd_pkg::OFS_STAT, 32'h3C);
		wr(uobpd_pkg::OFS_CTRL, 32'h20);
		cyc(6);
		chk(32'(hostRole), 32'h1);
		wr(uobpd_pkg::OFS_CTRL, 32'h2E);
		cyc(6);
		chk(32'(hostRole), 32'h0);
	endtask
	task automatic t_timer;
		for (int p = 0; p < 4; p++) begin
			for (int v = 0; v < 4; v++) begin
				wr(uobpd_pkg::OFS_CTRL, 32'(32'h3E | (p << 8) | (v << 12)));
				chk(timeoutCycles[p], cy(p, v));
			end
		end
		rg(uobpd_pkg::OFS_CTRL);
		chk(rd & 32'h3300, 32'h3300);
		wr(uobpd_pkg::OFS_CTRL, 32'h012E);
		chk(timeoutCycles[1], cy(1, 0));
		wr(uobpd_pkg::OFS_CTRL, 32'h212E);
		chk(timeoutCycles[1], cy(1, 0));
	endtask
	task automatic t_pad;
		wr(uobpd_pkg::OFS_CTRL, 32'h0D);
		cyc(3);
		chk(32'(padCtl), 32'h4);
		pulse(1'b1);
		chk(32'(padCtl), 32'h3);
		rg(uobpd_pkg::OFS_STAT);
		chk(rd & 32'h70, 32'h10);
		pulse(1'b0);
		rg(uobpd_pkg::OFS_STAT);
		chk(rd & 32'h70, 32'h60);
		wr(uobpd_pkg::OFS_CTRL, 32'h0F);
		pulse(1'b0);
		chk(32'(padActive), 32'h0);
		wr(uobpd_pkg::OFS_CTRL, 32'h0D);
		cyc(3);
		chk(32'(padActive), 32'h1);
	endtask
	task automatic t_region;
		cfg(0, 32'h31);
		cfg(1, 32'h45);
		cfg(2, 32'h01);
		ptr(0, 32'h0040_0000);
		ptr(1, 32'h0100_0040);
		ptr(2, 32'h0008_0140);
		cfg(1, 32'h47);
		cfg(1, 32'h45);
		rg(uobpd_pkg::OFS_RCFG);
		chk(rd, 32'h8000_0045);
		cfg(1, 32'h44);
		chk(32'({regionLostPulse, regionLostIndex}), 32'h12);
		ptr(2, 32'h0008_0040);
		cfg(1, 32'h45);
		chk(32'({regionLostPulse, regionLostIndex}), 32'h12);
		ptr(2, 32'h0008_0140);
		ptr(1, 32'h0100_0040);
		cfg(3, 32'h0D);
		rg(uobpd_pkg::OFS_RCFG);
		chk(rd & 32'h8000_0000, 32'h0);
		wr(uobpd_pkg::OFS_RSEL, 32'h0A);
		rg(uobpd_pkg::OFS_RCFG);
		chk(rd, 32'h0);
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_plug();
		t_timer();
		t_pad();
		t_region();
		end_of_test();
	end
endmodule
